// file: core/scss_pkg.sv
// constants, register map and timing for the system clock select and switch block
package scss_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TIMER_ONE = 8'h08;
  // osc_control_reg fields
  localparam int SEL_LSB = 0;
  localparam int FREQ_LSB = 3;
  localparam logic [1:0] SEL_RESET = 2'h0;
  localparam logic [3:0] FREQ_RESET = 4'h7;
  // osc_status_reg fields
  localparam int ST_FAST_STABLE = 0;
  localparam int ST_SLOW_READY = 1;
  localparam int ST_FAST_READY = 4;
  localparam int ST_EXT_ACTIVE = 5;
  localparam int ST_SEC_READY = 7;
  // timer_one_control field
  localparam int T1_SEC_EN = 3;
  localparam logic T1_SEC_EN_RESET = 1'h0;
  // config_osc_select encodings
  localparam logic [2:0] CFG_LOW_GAIN = 3'h0;
  localparam logic [2:0] CFG_MED_GAIN = 3'h1;
  localparam logic [2:0] CFG_HIGH_GAIN = 3'h2;
  localparam logic [2:0] CFG_RES_CAP = 3'h3;
  localparam logic [2:0] CFG_INTERNAL = 3'h4;
  // system clock sources
  localparam logic [1:0] SRC_PRI = 2'h0;
  localparam logic [1:0] SRC_SEC = 2'h1;
  localparam logic [1:0] SRC_INT = 2'h2;
  // highest code that picks the slow oscillator
  localparam logic [3:0] FREQ_SLOW_MAX = 4'h2;
  // timing, ref_clk period 5 ns
  localparam int CLK_NS = 5;
  localparam int FAST_WARM_NS = 2000;
  localparam int FAST_WARM_CYC = (FAST_WARM_NS + CLK_NS - 1) / CLK_NS;
  localparam int FAST_STABLE_NS = 1000;
  localparam int FAST_STABLE_CYC = (FAST_STABLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int FAST_HALF_NS = 31;
  localparam int FAST_HALF_CYC = FAST_HALF_NS / CLK_NS;
  localparam int SLOW_HALF_NS = 16129;
  localparam int SLOW_HALF_CYC = SLOW_HALF_NS / CLK_NS;
  localparam int SETTLE_EDGES = 1024;
endpackage

// file: core/scss_top.sv
// system clock source select, internal postscaler and glitch-free switch with apb registers
`timescale 1ns/100ps
// Function
// - sel 00 uses configured primary source
// - sel 01 uses secondary crystal oscillator
// - sel 1x uses internal block frequency
// - reset clears system clock select
// - automatic switches never touch select bits
// - reset loads frequency select 0111
// - postscaler gives 16 MHz to 31 kHz
// - duplicate codes, same-source changes faster
// - fast oscillator runs when needed
// - slow oscillator runs when needed
// - timers clocked from slow oscillator always
// - fast ready flag once running
// - fast stable flag near final frequency
// - slow ready flag once running
// - warm, falling edge, hold low, rising
// - same oscillator switch has no warm-up
// - status shows live oscillator state
// - osc pins become gpio or clkout
// - external active marks primary as the current system clock source
// - secondary enabled only by its bit
// - stabilisation delay before new source
// - settle timer counts 1024 primary edges
module scss_top #(
  parameter int FAST_WARM = scss_pkg::FAST_WARM_CYC,
  parameter int FAST_STABLE = scss_pkg::FAST_STABLE_CYC,
  parameter int FAST_HALF = scss_pkg::FAST_HALF_CYC,
  parameter int SLOW_HALF = scss_pkg::SLOW_HALF_CYC,
  parameter int SETTLE = scss_pkg::SETTLE_EDGES
) (
  input wire logic ref_clk, // 200 MHz clock
  input wire logic nrst, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [2:0] config_osc_select, // configuration oscillator mode
  input wire logic clock_out_enable_n, // low puts clock on out pin in internal and res-cap modes only
  input wire logic slow_periph_req, // a slow-clocked peripheral is enabled
  input wire logic clock_fail, // fail monitor reports lost clock
  input wire logic primary_osc_in_pin, // primary oscillator input level
  input wire logic secondary_xtal_in, // secondary oscillator level
  input wire logic gpio_out, // port data for out pin
  input wire logic gpio_oe, // port enable for out pin
  output logic sys_clk, // system clock level
  output logic slow_periph_clk, // clock for timers and monitor
  output logic fast_osc_run, // fast oscillator enable
  output logic slow_osc_run, // slow oscillator enable
  output logic secondary_osc_run, // secondary amplifier enable
  output logic primary_in_is_gpio, // in pin free for gpio
  output logic primary_out_o, // out pin output
  output logic primary_out_oe // out pin enable, high drives
);
  typedef enum logic [1:0] {ST_RUN, ST_WARM, ST_FALL, ST_RISE} scss_state_e;

  scss_state_e state_ff;
  logic [1:0] sel_ff;
  logic [3:0] freq_ff;
  logic sec_en_ff;
  logic [2:0] cfg_ff;
  logic cfg_done_ff;
  logic [15:0] fast_cnt_ff;
  logic fast_ready_ff, fast_stable_ff, fast_lvl_ff;
  logic [15:0] fast_ph_ff;
  logic [8:0] div_ff;
  logic [15:0] slow_ph_ff;
  logic slow_lvl_ff, slow_ready_ff;
  logic prim_d_ff, sec_d_ff;
  logic [10:0] ost_cnt_ff, sec_cnt_ff;
  logic ost_done_ff, sec_ready_ff;
  logic [1:0] cur_src_ff, tgt_src_ff;
  logic [3:0] cur_freq_ff, tgt_freq_ff;
  logic cur_prev_ff, new_prev_ff;
  logic ext_active_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;
  logic sys_clk_ff, slow_clk_ff, fast_run_ff, slow_run_ff, sec_run_ff;
  logic in_gpio_ff, out_o_ff, out_oe_ff;

  logic crystal, cfg_int, fast_run, slow_run, fast_rise;
  logic [1:0] want_src;
  logic cur_lvl, new_lvl, tgt_ready, differ, wr_go;
  logic [7:0] status;

  // duplicate codes share divider
  // code to postscaler exponent; one fast source keeps such changes quick
  function automatic logic [3:0] freq_exp(input logic [3:0] code);
    logic [3:0] e;
    e = 4'h0;
    case (code)
      4'hf: e = 4'h0;
      4'he: e = 4'h1;
      4'hd: e = 4'h2;
      4'hc: e = 4'h3;
      4'hb: e = 4'h4;
      4'ha, 4'h7: e = 4'h5;
      4'h9, 4'h6: e = 4'h6;
      4'h8, 4'h5: e = 4'h7;
      4'h4: e = 4'h8;
      4'h3: e = 4'h9;
      default: e = 4'h0;
    endcase
    return e;
  endfunction

  function automatic logic is_slow(input logic [3:0] code);
    return code <= scss_pkg::FREQ_SLOW_MAX;
  endfunction

  // level of a source; primary and secondary are sampled pins
  function automatic logic src_lvl(input logic [1:0] src, input logic [3:0] code,
                                   input logic fl, input logic [8:0] dv, input logic sl,
                                   input logic pl, input logic scl);
    logic [3:0] e;
    logic v;
    e = freq_exp(code);
    v = 1'b0;
    if (src == scss_pkg::SRC_PRI) begin
      v = pl;
    end else if (src == scss_pkg::SRC_SEC) begin
      v = scl;
    end else if (is_slow(code)) begin
      v = sl;
    end else if (e == 4'h0) begin
      v = fl;
    end else begin
      v = dv[e - 4'h1];
    end
    return v;
  endfunction

  assign crystal = (cfg_ff == scss_pkg::CFG_LOW_GAIN) || (cfg_ff == scss_pkg::CFG_MED_GAIN) ||
                   (cfg_ff == scss_pkg::CFG_HIGH_GAIN);
  assign cfg_int = (cfg_ff == scss_pkg::CFG_INTERNAL);

  // source wanted now; automatic fallbacks leave sel_ff alone
  always_comb begin
    want_src = scss_pkg::SRC_INT;
    if (sel_ff[1]) begin
      want_src = scss_pkg::SRC_INT;
    end else if (sel_ff[0]) begin
      want_src = scss_pkg::SRC_SEC;
    end else if (!cfg_int && !clock_fail && (!crystal || ost_done_ff)) begin
      want_src = scss_pkg::SRC_PRI;
    end
  end

  // fast oscillator enable, also while current or target uses it
  assign fast_run = (!is_slow(freq_ff) && (cfg_int || sel_ff[1])) ||
                    (cur_src_ff == scss_pkg::SRC_INT && !is_slow(cur_freq_ff)) ||
                    (state_ff != ST_RUN && tgt_src_ff == scss_pkg::SRC_INT && !is_slow(tgt_freq_ff));
  assign slow_run = (is_slow(freq_ff) && sel_ff[1]) || slow_periph_req ||
                    (cur_src_ff == scss_pkg::SRC_INT && is_slow(cur_freq_ff)) ||
                    (state_ff != ST_RUN && tgt_src_ff == scss_pkg::SRC_INT && is_slow(tgt_freq_ff));

  assign cur_lvl = src_lvl(cur_src_ff, cur_freq_ff, fast_lvl_ff, div_ff, slow_lvl_ff, prim_d_ff, sec_d_ff);
  assign new_lvl = src_lvl(tgt_src_ff, tgt_freq_ff, fast_lvl_ff, div_ff, slow_lvl_ff, prim_d_ff, sec_d_ff);
  assign differ = (want_src != cur_src_ff) || (want_src == scss_pkg::SRC_INT && freq_ff != cur_freq_ff);

  // target may drive only once its oscillator is usable
  always_comb begin
    tgt_ready = 1'b1;
    if (tgt_src_ff == scss_pkg::SRC_SEC) begin
      tgt_ready = sec_ready_ff;
    end else if (tgt_src_ff == scss_pkg::SRC_INT) begin
      tgt_ready = is_slow(tgt_freq_ff) ? slow_ready_ff : fast_ready_ff;
    end
  end

  // configuration strap caught at the first edge after release
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_ff <= scss_pkg::CFG_LOW_GAIN;
      cfg_done_ff <= 1'b0;
    end else if (!cfg_done_ff) begin
      cfg_ff <= config_osc_select;
      cfg_done_ff <= 1'b1;
    end
  end

  // fast oscillator model: level toggles from enable, warm-up count alongside
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fast_cnt_ff <= 16'h0;
      fast_ready_ff <= 1'b0;
      fast_stable_ff <= 1'b0;
      fast_ph_ff <= 16'h0;
      fast_lvl_ff <= 1'b0;
    end else if (!fast_run) begin
      fast_cnt_ff <= 16'h0;
      fast_ready_ff <= 1'b0;
      fast_stable_ff <= 1'b0;
      fast_ph_ff <= 16'h0;
      fast_lvl_ff <= 1'b0;
    end else begin
      if (fast_cnt_ff != 16'(FAST_WARM + FAST_STABLE)) begin
        fast_cnt_ff <= fast_cnt_ff + 16'h1;
      end
      fast_ready_ff <= fast_cnt_ff >= 16'(FAST_WARM);
      fast_stable_ff <= fast_cnt_ff >= 16'(FAST_WARM + FAST_STABLE);
      if (fast_ph_ff >= 16'(FAST_HALF - 1)) begin
        fast_ph_ff <= 16'h0;
        fast_lvl_ff <= ~fast_lvl_ff;
      end else begin
        fast_ph_ff <= fast_ph_ff + 16'h1;
      end
    end
  end

  assign fast_rise = fast_run && (fast_ph_ff >= 16'(FAST_HALF - 1)) && !fast_lvl_ff;

  // postscaler, bit n is fast divided by 2^(n+1)
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_ff <= 9'h0;
    end else if (fast_rise) begin
      div_ff <= div_ff + 9'h1;
    end
  end

  // slow oscillator model, ready after its first rising edge
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      slow_ph_ff <= 16'h0;
      slow_lvl_ff <= 1'b0;
      slow_ready_ff <= 1'b0;
    end else if (!slow_run) begin
      slow_ph_ff <= 16'h0;
      slow_lvl_ff <= 1'b0;
      slow_ready_ff <= 1'b0;
    end else if (slow_ph_ff >= 16'(SLOW_HALF - 1)) begin
      slow_ph_ff <= 16'h0;
      slow_lvl_ff <= ~slow_lvl_ff;
      if (!slow_lvl_ff) begin
        slow_ready_ff <= 1'b1;
      end
    end else begin
      slow_ph_ff <= slow_ph_ff + 16'h1;
    end
  end

  // primary settle timer, only crystal modes need it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prim_d_ff <= 1'b0;
      ost_cnt_ff <= 11'h0;
      ost_done_ff <= 1'b0;
    end else begin
      prim_d_ff <= primary_osc_in_pin;
      if (cfg_done_ff && crystal && !ost_done_ff && primary_osc_in_pin && !prim_d_ff) begin
        ost_cnt_ff <= ost_cnt_ff + 11'h1;
        ost_done_ff <= ost_cnt_ff == 11'(SETTLE - 1);
      end
    end
  end

  // secondary oscillator: runs only with its enable bit
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sec_d_ff <= 1'b0;
      sec_cnt_ff <= 11'h0;
      sec_ready_ff <= 1'b0;
    end else if (!sec_en_ff) begin
      sec_d_ff <= 1'b0;
      sec_cnt_ff <= 11'h0;
      sec_ready_ff <= 1'b0;
    end else begin
      sec_d_ff <= secondary_xtal_in;
      if (!sec_ready_ff && secondary_xtal_in && !sec_d_ff) begin
        sec_cnt_ff <= sec_cnt_ff + 11'h1;
        sec_ready_ff <= sec_cnt_ff == 11'(SETTLE - 1);
      end
    end
  end

  // switch sequencer; the target is frozen while a handover runs
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_RUN;
      cur_src_ff <= scss_pkg::SRC_INT;
      cur_freq_ff <= scss_pkg::FREQ_RESET;
      tgt_src_ff <= scss_pkg::SRC_INT;
      tgt_freq_ff <= scss_pkg::FREQ_RESET;
      cur_prev_ff <= 1'b0;
      new_prev_ff <= 1'b0;
    end else begin
      cur_prev_ff <= cur_lvl;
      new_prev_ff <= new_lvl;
      case (state_ff)
        ST_RUN: begin
          // any change of source, or of frequency while on the internal source
          if (cfg_done_ff && differ) begin
            tgt_src_ff <= want_src;
            tgt_freq_ff <= freq_ff;
            state_ff <= ST_WARM;
          end
        end
        ST_WARM: begin
          // a running oscillator passes at once
          if (tgt_ready) begin
            state_ff <= ST_FALL;
          end
        end
        ST_FALL: begin
          // wait falling edge of old clock
          if (cur_prev_ff && !cur_lvl) begin
            state_ff <= ST_RISE;
          end
        end
        ST_RISE: begin
          // output low until new rising edge
          if (!new_prev_ff && new_lvl) begin
            cur_src_ff <= tgt_src_ff;
            cur_freq_ff <= tgt_freq_ff;
            state_ff <= ST_RUN;
          end
        end
        default: state_ff <= ST_RUN;
      endcase
    end
  end

  // clock outputs; system clock held low during the handover gap
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sys_clk_ff <= 1'b0;
      slow_clk_ff <= 1'b0;
      fast_run_ff <= 1'b0;
      slow_run_ff <= 1'b0;
      sec_run_ff <= 1'b0;
    end else begin
      sys_clk_ff <= (state_ff == ST_RISE) ? 1'b0 : cur_lvl;
      slow_clk_ff <= slow_lvl_ff;
      fast_run_ff <= fast_run;
      slow_run_ff <= slow_run;
      sec_run_ff <= sec_en_ff;
    end
  end

  // status flag for external source, updated after handover
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ext_active_ff <= 1'b0;
    end else begin
      ext_active_ff <= (cur_src_ff == scss_pkg::SRC_PRI) && !cfg_int && (!crystal || ost_done_ff);
    end
  end

  // oscillator pins: crystal modes keep both pins
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      in_gpio_ff <= 1'b0;
      out_o_ff <= 1'b0;
      out_oe_ff <= 1'b0;
    end else begin
      in_gpio_ff <= cfg_int;
      if ((cfg_int || cfg_ff == scss_pkg::CFG_RES_CAP) && !clock_out_enable_n) begin
        out_o_ff <= sys_clk_ff;
        out_oe_ff <= 1'b1;
      end else if (cfg_int || cfg_ff == scss_pkg::CFG_RES_CAP || cfg_ff > scss_pkg::CFG_INTERNAL) begin
        out_o_ff <= gpio_out;
        out_oe_ff <= gpio_oe;
      end else begin
        out_o_ff <= 1'b0;
        out_oe_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    status = 8'h0;
    status[scss_pkg::ST_FAST_STABLE] = fast_stable_ff;
    status[scss_pkg::ST_SLOW_READY] = slow_ready_ff;
    status[scss_pkg::ST_FAST_READY] = fast_ready_ff;
    status[scss_pkg::ST_EXT_ACTIVE] = ext_active_ff;
    status[scss_pkg::ST_SEC_READY] = sec_ready_ff;
  end

  assign wr_go = psel && penable && pready_ff && pwrite;

  // control registers, written at the access edge
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sel_ff <= scss_pkg::SEL_RESET;
      // frequency select back to 500 kHz
      freq_ff <= scss_pkg::FREQ_RESET;
      sec_en_ff <= scss_pkg::T1_SEC_EN_RESET;
    end else if (wr_go && paddr == scss_pkg::OFS_CONTROL) begin
      // only software writes move the select
      sel_ff <= pwdata[scss_pkg::SEL_LSB +: 2];
      // any code accepted, decoded by freq_exp
      freq_ff <= pwdata[scss_pkg::FREQ_LSB +: 4];
    end else if (wr_go && paddr == scss_pkg::OFS_TIMER_ONE) begin
      sec_en_ff <= pwdata[scss_pkg::T1_SEC_EN];
    end
  end

  // apb answer prepared in setup, zero wait states
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= psel && !penable;
      prdata_ff <= 32'h0;
      pslverr_ff <= 1'b0;
      if (psel && !penable) begin
        case (paddr)
          scss_pkg::OFS_CONTROL: prdata_ff <= {25'h0, freq_ff, 1'b0, sel_ff};
          scss_pkg::OFS_STATUS: prdata_ff <= {24'h0, status};
          scss_pkg::OFS_TIMER_ONE: prdata_ff <= {28'h0, sec_en_ff, 3'h0};
          default: pslverr_ff <= 1'b1;
        endcase
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign sys_clk = sys_clk_ff;
  assign slow_periph_clk = slow_clk_ff;
  assign fast_osc_run = fast_run_ff;
  assign slow_osc_run = slow_run_ff;
  assign secondary_osc_run = sec_run_ff;
  assign primary_in_is_gpio = in_gpio_ff;
  assign primary_out_o = out_o_ff;
  assign primary_out_oe = out_oe_ff;
endmodule

// file: bench/scss_osc_model.sv
// stand-ins for the primary and watch crystals
`timescale 1ns/100ps
module scss_osc_model #(
  parameter int PRI_HALF_NS = 35,
  parameter int SEC_HALF_NS = 40
) (
  input wire logic sec_on, // secondary amplifier on
  output logic pri_lvl, // primary level
  output logic sec_lvl // watch crystal level
);
  // primary crystal swings freely, settle counting is the device's job
  initial begin
    pri_lvl = 1'b0;
    forever #(PRI_HALF_NS) pri_lvl = ~pri_lvl;
  end
  initial begin
    sec_lvl = 1'b0;
    forever begin
      #(SEC_HALF_NS);
      sec_lvl = sec_on ? ~sec_lvl : 1'b0;
    end
  end
endmodule

// file: bench/scss_chk_sva.sv
// port assertions for the clock select block
`timescale 1ns/100ps
module scss_chk (
  input wire logic ref_clk, // clock
  input wire logic nrst, // reset
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pwrite, // apb
  input wire logic [7:0] paddr, // apb
  input wire logic [31:0] pwdata, // apb
  input wire logic [31:0] prdata, // apb
  input wire logic pready, // apb
  input wire logic pslverr, // apb
  input wire logic [2:0] config_osc_select, // strap
  input wire logic clock_out_enable_n, // strap
  input wire logic slow_periph_req, // slow user
  input wire logic clock_fail, // monitor
  input wire logic primary_osc_in_pin, // primary
  input wire logic secondary_xtal_in, // secondary
  input wire logic gpio_out, // port data
  input wire logic gpio_oe, // port enable
  input wire logic sys_clk, // system clock
  input wire logic slow_periph_clk, // timer clock
  input wire logic fast_osc_run, // fast enable
  input wire logic slow_osc_run, // slow enable
  input wire logic secondary_osc_run, // sec enable
  input wire logic primary_in_is_gpio, // in pin
  input wire logic primary_out_o, // out pin
  input wire logic primary_out_oe // out pin enable
);
  logic [1:0] sel_ff; // software select
  logic [3:0] frq_ff; // software freq
  logic t1_ff; // software sec enable
  logic [1:0] up_ff; // edges since reset
  logic wr_acc; // write access edge
  logic gp_mode; // out pin free modes
  logic rd_st; // status read answer
  assign wr_acc = psel && penable && pready && pwrite;
  assign gp_mode = config_osc_select == scss_pkg::CFG_INTERNAL || config_osc_select == scss_pkg::CFG_RES_CAP;
  assign rd_st = pready && !pwrite && !pslverr && paddr == scss_pkg::OFS_STATUS;
  // mirror of what software wrote, so outputs can be tied to it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sel_ff <= scss_pkg::SEL_RESET;
      frq_ff <= scss_pkg::FREQ_RESET;
      t1_ff <= scss_pkg::T1_SEC_EN_RESET;
    end else if (wr_acc && paddr == scss_pkg::OFS_CONTROL) begin
      sel_ff <= pwdata[1:0];
      frq_ff <= pwdata[6:3];
    end else if (wr_acc && paddr == scss_pkg::OFS_TIMER_ONE) begin
      t1_ff <= pwdata[scss_pkg::T1_SEC_EN];
    end
  end
  // strap settles a few edges after release
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      up_ff <= 2'h0;
    end else if (up_ff != 2'h3) begin
      up_ff <= up_ff + 2'h1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  chk_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  chk_apb_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_bad_addr: assert property (psel && !penable && paddr > scss_pkg::OFS_TIMER_ONE |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_ctrl_view: assert property (
    pready && !pwrite && paddr == scss_pkg::OFS_CONTROL |-> prdata[1:0] == sel_ff && prdata[6:3] == frq_ff)
    else $error("control readback differs");
  chk_sec_enable: assert property (secondary_osc_run == $past(t1_ff))
    else $error("secondary enable not following bit");
  chk_gpio_pin: assert property (
    up_ff == 2'h3 |-> primary_in_is_gpio == (config_osc_select == scss_pkg::CFG_INTERNAL))
    else $error("in pin mode wrong");
  chk_out_gpio: assert property (
    up_ff == 2'h3 && gp_mode && clock_out_enable_n |=> primary_out_oe == $past(gpio_oe) && primary_out_o == $past(gpio_out))
    else $error("out pin not port driven");
  chk_out_clk: assert property (up_ff == 2'h3 && gp_mode && !clock_out_enable_n |=> primary_out_oe)
    else $error("out pin not driving clock");
  chk_fast_need: assert property (sel_ff[1] && frq_ff > scss_pkg::FREQ_SLOW_MAX |-> ##[0:2] fast_osc_run)
    else $error("fast oscillator off when needed");
  chk_slow_need: assert property (
    (sel_ff[1] && frq_ff <= scss_pkg::FREQ_SLOW_MAX) || slow_periph_req |-> ##[0:2] slow_osc_run)
    else $error("slow oscillator off when needed");
  chk_status_live: assert property (rd_st |-> (!prdata[scss_pkg::ST_FAST_STABLE] || prdata[scss_pkg::ST_FAST_READY])
    && (!prdata[scss_pkg::ST_FAST_READY] || $past(fast_osc_run) || $past(fast_osc_run, 2))
    && (!prdata[scss_pkg::ST_SLOW_READY] || $past(slow_osc_run) || $past(slow_osc_run, 2)))
    else $error("status flag without running oscillator");
  chk_clk_low: assert property ($fell(sys_clk) |=> !sys_clk)
    else $error("system clock low pulse too short");
  chk_slow_half: assert property ($fell(slow_periph_clk) && slow_osc_run |-> $past(slow_periph_clk, 8))
    else $error("timer clock high phase short");
  cover property (wr_acc && paddr == scss_pkg::OFS_CONTROL && pwdata[1:0] == scss_pkg::SRC_SEC);
  cover property ($rose(clock_fail) && sel_ff == scss_pkg::SRC_PRI);
  cover property (pready && pslverr);
endmodule
bind scss_top scss_chk u_chk (.*);

// file: bench/system_clock_select_and_switch_tb_top.sv
// self-checking bench for the clock select block
`timescale 1ns/100ps
module system_clock_select_and_switch_tb_top;
  localparam int FH = 2; // fast half, cycles
  localparam int SH = 8; // slow half, cycles
  localparam int PRI_NS = 35;
  localparam int SEC_NS = 40;
  logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] cfg;
  logic [3:0] code, mask;
  logic coe_n, spr, cfail, pri, sec, gout, goe, sys_clk, secrun;
  int n_fail, tests_run, per, k;
  integer seed;
  scss_top #(.FAST_WARM(4), .FAST_STABLE(4), .FAST_HALF(FH), .SLOW_HALF(SH), .SETTLE(8)) DUT (
    .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .config_osc_select(cfg), .clock_out_enable_n(coe_n), .slow_periph_req(spr),
    .clock_fail(cfail), .primary_osc_in_pin(pri), .secondary_xtal_in(sec), .gpio_out(gout),
    .gpio_oe(goe), .sys_clk(sys_clk), .slow_periph_clk(), .fast_osc_run(), .slow_osc_run(),
    .secondary_osc_run(secrun), .primary_in_is_gpio(), .primary_out_o(), .primary_out_oe());
  scss_osc_model #(.PRI_HALF_NS(PRI_NS), .SEC_HALF_NS(SEC_NS)) u_osc (
    .sec_on(secrun), .pri_lvl(pri), .sec_lvl(sec));
  // free-running reference clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic hang;
    n_fail++;
    $display("BAD wait exp done got timeout");
    complete_run;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic chk_per(input string nm, input int exp, input int got);
    tests_run++;
    if (got > exp + 1 || got < exp - 1) begin
      n_fail++;
      $display("BAD %s exp %0d got %0d", nm, exp, got);
    end
  endtask
  // one apb transfer, held until ready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (n > 50) hang;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // edges until the next sampled rise of the system clock
  task automatic rise(output int n);
    logic pv, cur;
    n = 0;
    pv = 1'b1;
    cur = 1'b1;
    while (!(pv === 1'b0 && cur === 1'b1)) begin
      pv = cur;
      @(posedge ref_clk);
      cur = sys_clk;
      n++;
      if (n > 9000) hang;
    end
  endtask
  // let a switch finish, then time one full period
  task automatic meas(output int p);
    int d;
    rise(d);
    rise(d);
    rise(p);
  endtask
  function automatic int exp_per(input logic [3:0] c);
    if (c <= scss_pkg::FREQ_SLOW_MAX) return 2 * SH;
    return (c[3] ? 1 << (15 - c) : 1 << (12 - c)) * 2 * FH;
  endfunction
  initial begin
    seed = 32'h89ca;
    n_fail = 0;
    tests_run = 0;
    {psel, penable, pwrite, coe_n, spr, cfail, gout, goe} = 8'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cfg = scss_pkg::CFG_INTERNAL;
    nrst = 1'b0;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    apb(1'b0, scss_pkg::OFS_CONTROL, 32'h0);
    chk("control reset", 32'h38, rd);
    apb(1'b1, 8'h0c, 32'hffffffff);
    chk("unmapped err", 32'h1, {31'h0, err});
    meas(per);
    chk_per("default period", exp_per(4'h7), per);
    // every frequency code once, in a seeded order, with random pin straps
    mask = 4'($random(seed));
    for (int i = 0; i < 16; i++) begin
      code = 4'(i) ^ mask;
      {spr, coe_n, gout, goe} <= 4'($random(seed));
      apb(1'b1, scss_pkg::OFS_CONTROL, {25'h0, code, 1'b0, scss_pkg::SRC_INT});
      meas(per);
      chk_per("internal period", exp_per(code), per);
      apb(1'b0, scss_pkg::OFS_STATUS, 32'h0);
      chk("fast flags", (code > scss_pkg::FREQ_SLOW_MAX) ? 32'h11 : 32'h0, rd & 32'h11);
      if (code <= scss_pkg::FREQ_SLOW_MAX) chk("slow ready", 32'h2, rd & 32'h2);
    end
    apb(1'b1, scss_pkg::OFS_TIMER_ONE, 32'(1) << scss_pkg::T1_SEC_EN);
    apb(1'b0, scss_pkg::OFS_TIMER_ONE, 32'h0);
    chk("timer one", 32'(1) << scss_pkg::T1_SEC_EN, rd);
    k = 0;
    // software waits for the watch crystal
    do begin
      apb(1'b0, scss_pkg::OFS_STATUS, 32'h0);
      k++;
      if (k > 200) hang;
    end while (rd[scss_pkg::ST_SEC_READY] !== 1'b1);
    apb(1'b1, scss_pkg::OFS_CONTROL, 32'h38 | 32'(scss_pkg::SRC_SEC));
    meas(per);
    chk_per("secondary period", 2 * SEC_NS / scss_pkg::CLK_NS, per);
    // crystal strap with a fresh reset in mid-run
    nrst <= 1'b0;
    cfg <= scss_pkg::CFG_LOW_GAIN;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    apb(1'b0, scss_pkg::OFS_STATUS, 32'h0);
    chk("settle pending", 32'h0, rd & 32'h20);
    meas(per);
    chk_per("primary period", 2 * PRI_NS / scss_pkg::CLK_NS, per);
    apb(1'b0, scss_pkg::OFS_STATUS, 32'h0);
    chk("external active", 32'h20, rd & 32'h20);
    cfail <= 1'b1;
    meas(per);
    chk_per("fail period", exp_per(4'h7), per);
    apb(1'b0, scss_pkg::OFS_CONTROL, 32'h0);
    chk("select kept", 32'h38, rd);
    apb(1'b0, scss_pkg::OFS_STATUS, 32'h0);
    chk("internal active", 32'h0, rd & 32'h20);
    complete_run;
  end
endmodule
